// *** bench/l3dif_checker.sv ***
// Concurrent checks on the ports of the decoder host interface
`timescale 1ns/10ps
module l3dif_checker #(
  parameter int unsigned ANC_DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire l3dif_pkg::l3dif_axi_m2s_t axi_i,
  input wire l3dif_pkg::l3dif_axi_s2m_t axi_o,
  input wire l3dif_pkg::l3dif_core_in_t core_i,
  input wire l3dif_pkg::l3dif_core_out_t core_o,
  input wire l3dif_pkg::l3dif_audio_t audio_o,
  input wire logic irq_o
);
  import l3dif_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // ****************************************
  // Bus handshakes
  // ****************************************
  wr_resp_a: assert property (axi_i.awvalid && axi_o.awready && axi_i.wvalid && axi_o.wready |-> ##2 axi_o.bvalid)
    else $error("write response late or missing");
  wr_done_a: assert property (axi_o.bvalid && axi_i.bready |=> !axi_o.bvalid)
    else $error("write response not retired");
  wr_block_a: assert property (axi_o.bvalid |-> !axi_o.awready && !axi_o.wready)
    else $error("write accepted while response pending");
  rd_lat_a: assert property (axi_i.arvalid && axi_o.arready |=> axi_o.rvalid)
    else $error("read data not one cycle after address");
  rd_done_a: assert property (axi_o.rvalid && axi_i.rready |=> !axi_o.rvalid)
    else $error("read data not retired");
  rd_block_a: assert property (axi_o.rvalid |-> !axi_o.arready)
    else $error("read accepted while data pending");

  // ****************************************
  // Decoder side
  // ****************************************
  byte_fwd_a: assert property (core_o.byte_valid |-> $rose(axi_o.bvalid))
    else $error("stream byte without a committing write");
  go_after_byte_a: assert property ($rose(core_o.go) |-> core_o.byte_valid || $past(core_o.byte_valid))
    else $error("decode started without a final byte");
  skip_cause_a: assert property (core_o.skip |-> $past(core_i.crc_err))
    else $error("frame skipped without a checksum error");
endmodule

bind l3dif_top l3dif_checker #(.ANC_DEPTH(ANC_DEPTH)) chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .axi_i(axi_i),
  .axi_o(axi_o), .core_i(core_i), .core_o(core_o), .audio_o(audio_o), .irq_o(irq_o));

// *** bench/l3dif_core_model.sv ***
// Behavioural model of the decoding core behind the host interface
`timescale 1ns/10ps
module l3dif_core_model (
  input wire logic clk_i,
  input wire l3dif_pkg::l3dif_core_out_t dec_i,
  output l3dif_pkg::l3dif_core_in_t ev_o,
  output int nbytes_o
);
  import l3dif_pkg::*;
  initial begin
    ev_o = '0;
    nbytes_o = 0;
  end
  always @(posedge clk_i) begin
    if (dec_i.byte_valid) begin
      nbytes_o <= nbytes_o + 1;
    end
  end
  // One-cycle event; call right after a rising edge, returns once the flag has landed
  task automatic pulse(input int k, input logic [10:0] v);
    l3dif_core_in_t c;
    c.crc_err = (k == 0);
    c.syn_err = (k == 1);
    c.lay_err = (k == 2);
    c.need = (k == 3);
    c.need_len = v;
    c.hdr_valid = (k == 4);
    c.hdr_ver = v[0];
    c.hdr_fs = v[2:1];
    c.anc_valid = (k == 5);
    c.anc_byte = v[7:0];
    // Never push into a full ancillary buffer
    while (k == 5 && !dec_i.anc_ready) @(posedge clk_i);
    ev_o <= c;
    @(posedge clk_i);
    ev_o <= '0;
    @(posedge clk_i);
  endtask
endmodule

// *** bench/l3dif_top_tb.sv ***
// Self-checking bench of the decoder host interface
`timescale 1ns/10ps
module l3dif_top_tb;
  import l3dif_pkg::*;
  logic clk_i;
  logic rst_b_i;
  l3dif_axi_m2s_t m;
  l3dif_axi_s2m_t s;
  l3dif_core_in_t cin;
  l3dif_core_out_t cout;
  l3dif_audio_t aud;
  logic irq;
  logic [1:0] rsp;
  int nb;
  int n;
  int checks = 0;
  int miscompares = 0;
  int cycles = 0;
  int skips = 0;
  logic [31:0] vals [5] = '{32'h1F, 32'h00, 32'h01, 32'h1E, 32'h02};

  l3dif_top uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .axi_i(m), .axi_o(s), .core_i(cin), .core_o(cout),
    .audio_o(aud), .irq_o(irq));
  l3dif_core_model core (.clk_i(clk_i), .dec_i(cout), .ev_o(cin), .nbytes_o(nb));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic close_out;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // bready and rready stay high: every answer is taken at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    m.awaddr <= a;
    m.wdata <= d;
    m.awvalid <= 1'b1;
    m.wvalid <= 1'b1;
    do begin
      @(posedge clk_i);
      if (m.awvalid && s.awready) m.awvalid <= 1'b0;
      if (m.wvalid && s.wready) m.wvalid <= 1'b0;
    end while (!s.bvalid);
    rsp = s.bresp;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk);
    m.araddr <= a;
    m.arvalid <= 1'b1;
    do begin
      @(posedge clk_i);
      if (m.arvalid && s.arready) m.arvalid <= 1'b0;
    end while (!s.rvalid);
    rsp = s.rresp;
    chk(s.rdata & mk, e);
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cout.skip) skips++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    m = '0;
    m.wstrb = 4'hF;
    m.bready = 1'b1;
    m.rready = 1'b1;
    rst_b_i = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    rd(OFS_CTRL, 32'h3F, '1);
    rd(OFS_STAT, 32'h01, '1);
    rd(OFS_STAT2, 32'h00, '1);
    rd(8'h2C, 32'h00, '1);
    chk(32'(rsp), 32'(RESP_SLVERR));
    wr(8'h2C, 32'h55);
    chk(32'(rsp), 32'(RESP_SLVERR));
    wr(OFS_STAT, 32'hFF);
    rd(OFS_STAT, 32'h01, '1);
    foreach (vals[k]) wr(OFS_VOL_L + 8'(4 * k), vals[k]);
    chk(32'(aud), {6'h00, 5'h1F, 5'h00, 5'h01, 5'h1E, 5'h02, 1'b0});
    rd(OFS_MED, 32'h1E, '1);
    // Enable with only the data request unmasked
    wr(OFS_CLKDIV, 32'h02);
    wr(OFS_CTRL, 32'hF7);
    chk(32'(aud.boost), 32'h1);
    n = 0;
    repeat (30) begin
      @(posedge clk_i);
      n += int'(cout.dclk_tick);
    end
    chk(n, 10);
    rd(OFS_STAT, 32'h40, 32'h40);
    rd(OFS_STAT, 32'h40, 32'h40);
    rd(OFS_STAT2, 32'h10, 32'h18);
    chk(32'(irq), 32'h1);
    wr(OFS_STREAM, 32'h00);
    rd(OFS_STAT2, 32'h18, 32'h18);
    chk(32'(cout.go), 32'h0);
    for (int i = 1; i < 1024; i++) wr(OFS_STREAM, 32'(i & 8'hFF));
    @(posedge clk_i);
    chk(nb, 1024);
    rd(OFS_STAT2, 32'h00, 32'h18);
    rd(OFS_STAT, 32'h00, 32'h40);
    chk(32'(cout.go), 32'h1);
    chk(32'(irq), 32'h0);
    core.pulse(3, 11'd2);
    rd(OFS_STAT2, 32'h10, 32'h10);
    chk(32'(cout.go), 32'h0);
    wr(OFS_STREAM, 32'hA1);
    wr(OFS_STREAM, 32'hA2);
    chk(32'(cout.go), 32'h1);
    // Each error with its mask set, then cleared
    for (int k = 0; k < 3; k++) begin
      wr(OFS_CTRL, 32'h9F);
      core.pulse(k, 11'd0);
      chk(32'(irq), 32'h0);
      wr(OFS_CTRL, 32'h9F & ~(32'h1 << k));
      chk(32'(irq), 32'h1);
      rd(OFS_STAT, 32'h08 << k, 32'h38);
      rd(OFS_STAT, 32'h00, 32'h38);
      chk(32'(irq), 32'h0);
    end
    chk(skips, 1);
    // Play enable set: a corrupted frame is not skipped
    wr(OFS_CTRL, 32'hBF);
    core.pulse(0, 11'd0);
    rd(OFS_STAT, 32'h08, 32'h38);
    chk(skips, 1);
    for (int i = 0; i < 8; i++) begin
      core.pulse(4, 11'(i));
      rd(OFS_STAT, 32'(i), 32'h07);
    end
    wr(OFS_CTRL, 32'h8F);
    core.pulse(5, 11'hA5);
    core.pulse(5, 11'h3C);
    chk(32'(irq), 32'h1);
    rd(OFS_STAT, 32'h80, 32'h80);
    rd(OFS_ANC, 32'hA5, 32'hFF);
    rd(OFS_STAT, 32'h80, 32'h80);
    rd(OFS_ANC, 32'h3C, 32'hFF);
    rd(OFS_STAT, 32'h00, 32'h80);
    chk(32'(irq), 32'h0);
    close_out();
  end
endmodule

// *** src/l3dif_pkg.sv ***
// Package: constants, register map and carrier types of the layer 3 decoder host interface
package l3dif_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STAT2 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STREAM = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_ANC = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_VOL_L = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_VOL_R = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_BASS = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_MED = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_TRE = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_CLKDIV = 8'h28;

  typedef enum logic [3:0] {
    L3DIF_R_CTRL, L3DIF_R_STAT, L3DIF_R_STAT2, L3DIF_R_STREAM, L3DIF_R_ANC, L3DIF_R_VOL_L,
    L3DIF_R_VOL_R, L3DIF_R_BASS, L3DIF_R_MED, L3DIF_R_TRE, L3DIF_R_CLKDIV, L3DIF_R_NONE
  } l3dif_reg_t;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int unsigned CTRL_EN = 7;
  localparam int unsigned CTRL_BOOST = 6;
  localparam int unsigned CTRL_CRC_PLAY = 5;
  localparam int unsigned CTRL_MSK_ANC = 4;
  localparam int unsigned CTRL_MSK_REQ = 3;
  localparam int unsigned CTRL_MSK_LAY = 2;
  localparam int unsigned CTRL_MSK_SYN = 1;
  localparam int unsigned CTRL_MSK_CRC = 0;
  localparam logic [7:0] CTRL_RST = 8'h3F;
  localparam logic VER_RST = 1'b1;
  localparam int unsigned CODE_W = 5;
  localparam int unsigned LEN_W = 11;
  localparam logic [LEN_W-1:0] FIRST_REQ_BYTES = 11'h400;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Code meanings, used by the decoding datapath
  localparam logic [CODE_W-1:0] VOL_MUTE = 5'h00;
  localparam logic [CODE_W-1:0] VOL_FULL = 5'h1F;
  localparam logic [1:0] FS_RESERVED = 2'h3;
  localparam int unsigned EQ_BASS_TOP_HZ = 750;
  localparam int unsigned EQ_TREBLE_LOW_HZ = 3300;
  localparam int unsigned BOOST_TOP_HZ = 375;
  localparam int unsigned BOOST_GAIN_DB = 9;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } l3dif_axi_m2s_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } l3dif_axi_s2m_t;

  typedef struct packed {
    logic need;
    logic [LEN_W-1:0] need_len;
    logic hdr_valid;
    logic hdr_ver;
    logic [1:0] hdr_fs;
    logic lay_err;
    logic syn_err;
    logic crc_err;
    logic anc_valid;
    logic [7:0] anc_byte;
  } l3dif_core_in_t;

  typedef struct packed {
    logic byte_valid;
    logic [7:0] byte_data;
    logic go;
    logic skip;
    logic dclk_tick;
    logic anc_ready;
  } l3dif_core_out_t;

  typedef struct packed {
    logic [CODE_W-1:0] vol_l;
    logic [CODE_W-1:0] vol_r;
    logic [CODE_W-1:0] bass;
    logic [CODE_W-1:0] med;
    logic [CODE_W-1:0] tre;
    logic boost;
  } l3dif_audio_t;

endpackage

// *** src/l3dif_top.sv ***
// Host-side control and status logic of the layer 3 audio decoder
//
// Notes on behaviour
// - Decoding of a frame waits until the whole frame is loaded.
// - A data request sets data and frame request flags.
// - Frame request flag holds while requesting, clears when done, sets again later.
// - Byte request flag toggles on every stream byte write.
// - First request after enable asks for a full buffer of bytes.
// - Decoder clock is the fast clock divided by the 5-bit factor plus one.
// - Each channel has a 5-bit volume code, zero mutes, all ones 0 dB.
// - Equalizer bands split at 750 Hz and 3300 Hz.
// - Each band has a 5-bit gain code from minus infinity to +1.5 dB.
// - Bass boost adds 9 dB below 375 Hz when enabled.
// - Unsupported layer in a header sets the layer error flag.
// - Missing synchronisation pattern sets the sync error flag.
// - Checksum mismatch sets the CRC error flag; play enable picks play or skip.
// - Version bit and 2-bit rate code report the sampling rate.
// - Ancillary flag is set while the ancillary buffer is not empty.
// - Five interrupt sources, each with its own mask bit.
// - Reading main status clears the three error flags only.
// - Hardware clears data request and ancillary flags when their cause ends.
// - Play enable set plays a corrupted frame, clear skips it.
// - A set mask bit keeps its flag off the interrupt.
// - The decoder runs only while the enable bit is set.
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps

module l3dif_top #(
  parameter int unsigned ANC_DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire l3dif_pkg::l3dif_axi_m2s_t axi_i,
  output l3dif_pkg::l3dif_axi_s2m_t axi_o,
  input wire l3dif_pkg::l3dif_core_in_t core_i,
  output l3dif_pkg::l3dif_core_out_t core_o,
  output l3dif_pkg::l3dif_audio_t audio_o,
  output logic irq_o
);
  import l3dif_pkg::*;

  // ****************************************
  // Sizes and state
  // ****************************************
  // Count is one bit wider than the pointers to tell full from empty
  localparam int unsigned PTR_W = (ANC_DEPTH > 1) ? $clog2(ANC_DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(ANC_DEPTH + 1);
  localparam logic [CNT_W-1:0] ANC_FULL = CNT_W'(ANC_DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(ANC_DEPTH - 1);

  typedef struct packed {
    l3dif_axi_s2m_t axi;
    l3dif_core_out_t core;
    l3dif_audio_t audio;
    logic irq;
    logic [7:0] ctrl;
    logic [CODE_W-1:0] clk_div;
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [7:0] w_byte;
    logic w_lane;
    logic en_prev;
    logic [LEN_W-1:0] remaining;
    logic loaded;
    logic data_req;
    logic frame_req;
    logic byte_req;
    logic lay_err;
    logic syn_err;
    logic crc_err;
    logic ver;
    logic [1:0] fs;
    logic anc_flag;
    logic [PTR_W-1:0] anc_wr;
    logic [PTR_W-1:0] anc_rd;
    logic [CNT_W-1:0] anc_cnt;
    logic [CODE_W-1:0] div_cnt;
  } l3dif_state_t;
  // All state but the ancillary storage in one record: one comb fill, one register

  // ****************************************
  // Address decode
  // ****************************************
  function automatic l3dif_reg_t l3dif_sel(input logic [ADDR_W-1:0] a);
    l3dif_reg_t r;
    if (a == OFS_CTRL) begin
      r = L3DIF_R_CTRL;
    end else if (a == OFS_STAT) begin
      r = L3DIF_R_STAT;
    end else if (a == OFS_STAT2) begin
      r = L3DIF_R_STAT2;
    end else if (a == OFS_STREAM) begin
      r = L3DIF_R_STREAM;
    end else if (a == OFS_ANC) begin
      r = L3DIF_R_ANC;
    end else if (a == OFS_VOL_L) begin
      r = L3DIF_R_VOL_L;
    end else if (a == OFS_VOL_R) begin
      r = L3DIF_R_VOL_R;
    end else if (a == OFS_BASS) begin
      r = L3DIF_R_BASS;
    end else if (a == OFS_MED) begin
      r = L3DIF_R_MED;
    end else if (a == OFS_TRE) begin
      r = L3DIF_R_TRE;
    end else if (a == OFS_CLKDIV) begin
      r = L3DIF_R_CLKDIV;
    end else begin
      r = L3DIF_R_NONE;
    end
    return r;
  endfunction

  l3dif_state_t q;
  l3dif_state_t d;
  // Ancillary bytes; the buffer is small, so a plain array
  logic [7:0] anc_mem [ANC_DEPTH];
  logic anc_push;
  logic anc_pop;
  logic stat_rd;
  logic en;
  l3dif_reg_t wsel;
  l3dif_reg_t rsel;
  logic [4:0] flags;
  logic [4:0] masks;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    d = q;
    anc_push = 1'b0;
    anc_pop = 1'b0;
    stat_rd = 1'b0;
    en = q.ctrl[CTRL_EN];
    wsel = l3dif_sel(q.aw_addr);
    rsel = l3dif_sel(axi_i.araddr);
    d.core.byte_valid = 1'b0;
    d.core.skip = 1'b0;
    d.core.dclk_tick = 1'b0;

    // ****************************************
    // Write channel
    // ****************************************
    // Address and data taken in either order
    if (axi_i.awvalid && q.axi.awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = axi_i.awaddr;
    end
    if (axi_i.wvalid && q.axi.wready) begin
      // Only byte lane 0 carries a register
      d.w_have = 1'b1;
      d.w_byte = axi_i.wdata[7:0];
      d.w_lane = axi_i.wstrb[0];
    end
    if (axi_i.bready && q.axi.bvalid) begin
      d.axi.bvalid = 1'b0;
    end
    // Commit only once both halves are held and no answer is pending
    if (q.aw_have && q.w_have && !q.axi.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.axi.bvalid = 1'b1;
      d.axi.bresp = RESP_OKAY;
      if (wsel == L3DIF_R_NONE) begin
        // Unmapped: error answer, nothing written
        d.axi.bresp = RESP_SLVERR;
      end else if (q.w_lane) begin
        if (wsel == L3DIF_R_CTRL) begin
          d.ctrl = q.w_byte;
        end else if (wsel == L3DIF_R_STREAM) begin
          d.byte_req = ~q.byte_req;
          if (en) begin
            d.core.byte_valid = 1'b1;
            d.core.byte_data = q.w_byte;
            if (q.remaining != '0) begin
              d.remaining = q.remaining - LEN_W'(1);
              d.loaded = (q.remaining == LEN_W'(1));
            end
          end
        end else if (wsel == L3DIF_R_VOL_L) begin
          d.audio.vol_l = q.w_byte[CODE_W-1:0];
        end else if (wsel == L3DIF_R_VOL_R) begin
          d.audio.vol_r = q.w_byte[CODE_W-1:0];
        end else if (wsel == L3DIF_R_BASS) begin
          d.audio.bass = q.w_byte[CODE_W-1:0];
        end else if (wsel == L3DIF_R_MED) begin
          d.audio.med = q.w_byte[CODE_W-1:0];
        end else if (wsel == L3DIF_R_TRE) begin
          d.audio.tre = q.w_byte[CODE_W-1:0];
        end else if (wsel == L3DIF_R_CLKDIV) begin
          d.clk_div = q.w_byte[CODE_W-1:0];
        end
      end
    end

    // ****************************************
    // Read channel
    // ****************************************
    // The answer holds the value before any side effect
    if (axi_i.rready && q.axi.rvalid) begin
      d.axi.rvalid = 1'b0;
    end
    if (axi_i.arvalid && q.axi.arready) begin
      d.axi.rvalid = 1'b1;
      d.axi.rresp = RESP_OKAY;
      d.axi.rdata = '0;
      if (rsel == L3DIF_R_CTRL) begin
        d.axi.rdata[7:0] = q.ctrl;
      end else if (rsel == L3DIF_R_STAT) begin
        d.axi.rdata[7] = q.anc_flag;
        d.axi.rdata[6] = q.data_req;
        d.axi.rdata[5] = q.lay_err;
        d.axi.rdata[4] = q.syn_err;
        d.axi.rdata[3] = q.crc_err;
        d.axi.rdata[2:1] = q.fs;
        d.axi.rdata[0] = q.ver;
        stat_rd = 1'b1;
      end else if (rsel == L3DIF_R_STAT2) begin
        d.axi.rdata[4] = q.frame_req;
        d.axi.rdata[3] = q.byte_req;
      end else if (rsel == L3DIF_R_ANC) begin
        d.axi.rdata[7:0] = anc_mem[q.anc_rd];
        anc_pop = (q.anc_cnt != '0);
      end else if (rsel == L3DIF_R_VOL_L) begin
        d.axi.rdata[CODE_W-1:0] = q.audio.vol_l;
      end else if (rsel == L3DIF_R_VOL_R) begin
        d.axi.rdata[CODE_W-1:0] = q.audio.vol_r;
      end else if (rsel == L3DIF_R_BASS) begin
        d.axi.rdata[CODE_W-1:0] = q.audio.bass;
      end else if (rsel == L3DIF_R_MED) begin
        d.axi.rdata[CODE_W-1:0] = q.audio.med;
      end else if (rsel == L3DIF_R_TRE) begin
        d.axi.rdata[CODE_W-1:0] = q.audio.tre;
      end else if (rsel == L3DIF_R_CLKDIV) begin
        d.axi.rdata[CODE_W-1:0] = q.clk_div;
      end else if (rsel == L3DIF_R_NONE) begin
        // Unmapped: error answer, zero data
        d.axi.rresp = RESP_SLVERR;
      end
    end

    // ****************************************
    // Load handshake
    // ****************************************
    // A new need is ignored while a load is still pending
    d.en_prev = en;
    if (!en) begin
      d.remaining = '0;
      d.loaded = 1'b0;
    end else if (!q.en_prev) begin
      d.remaining = FIRST_REQ_BYTES;
      d.loaded = 1'b0;
    end else if (core_i.need && q.remaining == '0) begin
      d.remaining = core_i.need_len;
      d.loaded = 1'b0;
    end
    // Data request equals frame request; only hardware clears it
    d.frame_req = (d.remaining != '0);
    d.data_req = (d.remaining != '0);
    d.core.go = en && d.loaded;

    // ****************************************
    // Error flags
    // ****************************************
    // The read clears first so a same-cycle event still sets
    if (stat_rd) begin
      d.lay_err = 1'b0;
      d.syn_err = 1'b0;
      d.crc_err = 1'b0;
    end
    // Events count only while enabled
    if (en) begin
      d.lay_err = d.lay_err | core_i.lay_err;
      d.syn_err = d.syn_err | core_i.syn_err;
      d.crc_err = d.crc_err | core_i.crc_err;
      d.core.skip = core_i.crc_err && !q.ctrl[CTRL_CRC_PLAY];
      if (core_i.hdr_valid) begin
        d.ver = core_i.hdr_ver;
        d.fs = core_i.hdr_fs;
      end
    end

    // ****************************************
    // Ancillary buffer
    // ****************************************
    // A read of an empty buffer pops nothing; its data are stale
    anc_push = core_i.anc_valid && q.core.anc_ready;
    if (anc_push) begin
      d.anc_wr = (q.anc_wr == PTR_LAST) ? '0 : q.anc_wr + PTR_W'(1);
    end
    if (anc_pop) begin
      d.anc_rd = (q.anc_rd == PTR_LAST) ? '0 : q.anc_rd + PTR_W'(1);
    end
    if (anc_push && !anc_pop) begin
      d.anc_cnt = q.anc_cnt + CNT_W'(1);
    end else if (anc_pop && !anc_push) begin
      d.anc_cnt = q.anc_cnt - CNT_W'(1);
    end
    d.anc_flag = (d.anc_cnt != '0);
    // Ready is registered, so one slot is kept back for a push already in flight
    d.core.anc_ready = (d.anc_cnt < ANC_FULL - CNT_W'(1)) || (d.anc_cnt == '0);

    // ****************************************
    // Decoder clock divider
    // ****************************************
    // A tick enable, not a new clock: the block stays on one clock
    if (!en || q.div_cnt >= q.clk_div) begin
      d.div_cnt = '0;
      d.core.dclk_tick = en;
    end else begin
      d.div_cnt = q.div_cnt + CODE_W'(1);
    end


    // ****************************************
    // Audio settings and interrupt
    // ****************************************
    d.audio.boost = d.ctrl[CTRL_BOOST];
    flags[0] = d.crc_err;
    flags[1] = d.syn_err;
    flags[2] = d.lay_err;
    flags[3] = d.data_req;
    flags[4] = d.anc_flag;
    masks[0] = d.ctrl[CTRL_MSK_CRC];
    masks[1] = d.ctrl[CTRL_MSK_SYN];
    masks[2] = d.ctrl[CTRL_MSK_LAY];
    masks[3] = d.ctrl[CTRL_MSK_REQ];
    masks[4] = d.ctrl[CTRL_MSK_ANC];
    d.irq = |(flags & ~masks);

    // Readies drop while a request is held, which refuses a second one
    d.axi.awready = !d.aw_have && !d.axi.bvalid;
    d.axi.wready = !d.w_have && !d.axi.bvalid;
    d.axi.arready = !d.axi.rvalid;
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.ver <= VER_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Ancillary storage
  // ****************************************
  // Storage only; pointers and count live in the state
  always_ff @(posedge clk_i) begin
    if (anc_push) begin
      anc_mem[q.anc_wr] <= core_i.anc_byte;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every output is a register copy; no logic after the flops
  assign axi_o = q.axi;
  assign core_o = q.core;
  assign audio_o = q.audio;
  assign irq_o = q.irq;

endmodule
